// File: rtl/seq_pkg.sv
// Constants, encodings and timing for the parallel strobe sequencer
package seq_pkg;
   localparam int CMD_W = 16;
   localparam int DATA_W = 8;
   localparam int DIN_W = 16;
   localparam int STAT_W = 8;
   localparam int FIFO_DEPTH = 16;
   // Command word fields
   localparam int CMD_MODE_LD = 10;
   localparam int CMD_BEGIN = 9;
   localparam int CMD_BR_HI = 7;
   localparam int CMD_BR_LO = 4;
   localparam int CMD_MD_HI = 3;
   localparam int CMD_MD_LO = 0;
   localparam int MODE_IN_BIT = 3;
   localparam int MODE_DATA_BIT = 2;
   // Mode codes
   localparam logic [3:0] MODE_OUT_DATA = 4'h4;
   localparam logic [3:0] MODE_OUT_CMD = 4'h0;
   localparam logic [3:0] MODE_IN_DATA = 4'hC;
   localparam logic [3:0] MODE_IN_STAT = 4'h8;
   localparam logic [3:0] MODE_RESET = MODE_OUT_CMD;
   // Sequence addresses
   localparam logic [3:0] ADDR_IDLE = 4'h0;
   localparam logic [3:0] ADDR_STEP = 4'h1;
   localparam logic [3:0] ADDR_3 = 4'h3;
   localparam logic [3:0] ADDR_4 = 4'h4;
   localparam logic [3:0] ADDR_AUTO_OUT = 4'h5;
   localparam logic [3:0] ADDR_AUTO_IN = 4'h6;
   localparam logic [3:0] ADDR_EOB = 4'hF;
   // Timing
   localparam int CLK_NS = 10;
   localparam int TICK_NS = 250;
   localparam int STEP_NS = 500;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int STEP_TICKS = STEP_NS / TICK_NS;
   localparam int DIV_W = 5;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);
   localparam logic [1:0] STEP_LAST = 2'(STEP_TICKS - 1);
   // Status word bit positions
   localparam int ST_STOP = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_ACK = 2;
   localparam int ST_TWO_N = 3;
   localparam int ST_IRQ = 4;
   typedef enum logic [2:0] {
      S_IDLE, S_STEP, S_FS, S_HIGH, S_END, S_EOB
   } seq_state_e;
endpackage

// File: rtl/strobe_sequencer.sv
// Parallel strobe sequencer top with its output data FIFO
`timescale 1ns/10ps

// ----------------------------------------
// Output data FIFO
// ----------------------------------------
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk, // Clock
   input wire logic rst, // Synchronous reset
   input wire logic wr_valid, // Write offered
   output logic wr_ready, // Space available
   input wire logic [WIDTH-1:0] wr_data, // Write data
   output logic rd_valid, // Data available
   input wire logic rd_ready, // Read taken
   output logic [WIDTH-1:0] rd_data // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   wire do_wr = wr_valid && wr_ready;
   wire do_rd = rd_valid && rd_ready;
   // Ready is a flop fed by the next count, so the top output is registered
   wire [AW:0] cnt_next = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   assign rd_valid = cnt_reg != '0;
   assign rd_data = mem[rp_reg];
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wp_reg] <= wr_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
         wr_ready <= 1'b1;
      end else begin
         if (do_wr) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (do_rd) begin
            rp_reg <= rp_reg + 1'b1;
         end
         cnt_reg <= cnt_next;
         wr_ready <= cnt_next != (AW+1)'(DEPTH);
      end
   end
endmodule

// ----------------------------------------
// Sequencer
// ----------------------------------------
module strobe_sequencer (
   input wire logic mclk, // 100 MHz clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic cmd_valid, // Command word strobe
   input wire logic [seq_pkg::CMD_W-1:0] cmd_word, // Mode and branch
   input wire logic eob_ack, // CPU recognised interrupt
   input wire logic wr_valid, // Output byte offered
   output logic wr_ready, // FIFO can take a byte
   input wire logic [seq_pkg::DATA_W-1:0] wr_data, // Output byte
   input wire logic stop_pin, // Peripheral stop status
   input wire logic busy_pin, // Peripheral busy status
   input wire logic strobe_ack_pin, // Strobe acknowledge
   input wire logic two_byte_n_pin, // Low for 16-bit peripheral
   input wire logic [seq_pkg::DIN_W-1:0] data_in_pin, // Input lines
   output logic step_out, // Step pulse
   output logic function_strobe_line, // Function strobe
   output logic end_out, // End line
   output logic end_of_block, // End-of-block interrupt
   output logic high_byte_select, // High byte routed
   output logic dir_input, // Mode is input
   output logic data_mode, // Mode is data, not command
   output logic [seq_pkg::DATA_W-1:0] data_out, // Output data lines
   output logic [seq_pkg::DATA_W-1:0] rd_byte, // Selected input byte
   output logic [seq_pkg::STAT_W-1:0] status_word // Device status
);
   import seq_pkg::*;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] st_m_reg;
   logic [3:0] st_s_reg;
   logic [DIN_W-1:0] din_m_reg;
   logic [DIN_W-1:0] din_s_reg;
   always_ff @(posedge mclk) begin
      st_m_reg <= {two_byte_n_pin, strobe_ack_pin, busy_pin, stop_pin};
      st_s_reg <= st_m_reg;
      din_m_reg <= data_in_pin;
      din_s_reg <= din_m_reg;
   end
   wire two_byte_s = ~st_s_reg[3];

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic [3:0] mode_reg;
   wire begin_take = cmd_valid && cmd_word[CMD_BEGIN];
   wire mode_take = cmd_valid && cmd_word[CMD_MODE_LD];
   wire [3:0] cmd_mode = cmd_word[CMD_MD_HI:CMD_MD_LO];
   wire [3:0] cmd_addr = cmd_word[CMD_BR_HI:CMD_BR_LO];
   // Mode in the same word applies to its own branch
   wire [3:0] mode_now = mode_take ? cmd_mode : mode_reg;
   wire in_now = mode_now[MODE_IN_BIT];

   // Sequence address to entry state for the given direction
   function automatic seq_state_e entry(input logic [3:0] addr,
                                        input logic in_dir);
      case (addr)
         ADDR_IDLE: entry = S_IDLE;
         ADDR_STEP, ADDR_AUTO_OUT, ADDR_AUTO_IN: entry = S_STEP;
         ADDR_3: entry = in_dir ? S_HIGH : S_FS;
         ADDR_4: entry = in_dir ? S_FS : S_END;
         ADDR_EOB: entry = S_EOB;
         default: entry = S_IDLE;
      endcase
   endfunction

   // ----------------------------------------
   // 500 ns step timer, counting 250 ns ticks
   // ----------------------------------------
   logic [DIV_W-1:0] div_reg;
   logic [1:0] stc_reg;
   seq_state_e st_reg;
   seq_state_e st_next;
   wire tick = div_reg == DIV_LAST;
   wire step_done = tick && stc_reg == STEP_LAST;
   always_ff @(posedge mclk) begin
      if (sys_rst || begin_take || tick) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (sys_rst || begin_take || st_reg != S_STEP) begin
         stc_reg <= '0;
      end else if (tick) begin
         stc_reg <= stc_reg + 1'b1;
      end
   end

   // ----------------------------------------
   // Sequence state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      if (begin_take) begin
         st_next = entry(cmd_addr, in_now);
      end else begin
         case (st_reg)
            S_STEP: begin
               if (step_done && !mode_reg[MODE_IN_BIT]) begin
                  st_next = S_FS;
               end else if (step_done) begin
                  st_next = two_byte_s ? S_HIGH : S_IDLE;
               end
            end
            S_EOB: begin
               if (eob_ack) begin
                  st_next = S_IDLE;
               end
            end
            default: st_next = st_reg;
         endcase
      end
   end

   wire out_dir_next = !(begin_take ? in_now : mode_reg[MODE_IN_BIT]);
   wire step_next = st_next == S_STEP;
   // Output strobe rides along with the step pulse
   wire fs_next = st_next == S_FS
                  || (step_next && out_dir_next);
   wire end_next = st_next == S_END || st_next == S_EOB;
   wire irq_next = st_next == S_EOB;
   wire hi_next = st_next == S_HIGH;
   // Fresh byte moves to the lines only when a strobe is begun
   wire load_out = begin_take && out_dir_next
                   && (st_next == S_STEP || st_next == S_FS);
   wire fifo_valid;
   wire [DATA_W-1:0] fifo_data;
   wire pop = load_out && fifo_valid;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_reg <= S_IDLE;
         mode_reg <= MODE_RESET;
         step_out <= 1'b0;
         function_strobe_line <= 1'b0;
         end_out <= 1'b0;
         end_of_block <= 1'b0;
         high_byte_select <= 1'b0;
         dir_input <= 1'b0;
         data_mode <= 1'b0;
         data_out <= '0;
      end else begin
         st_reg <= st_next;
         if (mode_take) begin
            mode_reg <= cmd_mode;
         end
         step_out <= step_next;
         function_strobe_line <= fs_next;
         end_out <= end_next;
         end_of_block <= irq_next;
         high_byte_select <= hi_next;
         dir_input <= mode_now[MODE_IN_BIT];
         data_mode <= mode_now[MODE_DATA_BIT];
         if (pop) begin
            data_out <= fifo_data;
         end
      end
   end

   // ----------------------------------------
   // Read side
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rd_byte <= '0;
         status_word <= '0;
      end else begin
         rd_byte <= high_byte_select
                    ? din_s_reg[DIN_W-1:DATA_W] : din_s_reg[DATA_W-1:0];
         status_word <= '0;
         status_word[ST_STOP] <= st_s_reg[0];
         status_word[ST_BUSY] <= st_s_reg[1];
         status_word[ST_ACK] <= st_s_reg[2];
         status_word[ST_TWO_N] <= st_s_reg[3];
         status_word[ST_IRQ] <= end_of_block;
      end
   end

   byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(mclk),
      .rst(sys_rst),
      .wr_valid(wr_valid),
      .wr_ready(wr_ready),
      .wr_data(wr_data),
      .rd_valid(fifo_valid),
      .rd_ready(pop),
      .rd_data(fifo_data)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Step age restarts with every Begin, since a new Begin restarts the pulse
   localparam int STEP_CYC = STEP_NS / CLK_NS;
   logic [6:0] step_age_reg;
   wire [DATA_W-1:0] din_hi = din_s_reg[DIN_W-1:DATA_W];
   wire [DATA_W-1:0] din_lo = din_s_reg[DATA_W-1:0];
   wire ack_s = st_s_reg[2];
   always_ff @(posedge mclk) begin
      if (sys_rst || begin_take || !step_out) begin
         step_age_reg <= '0;
      end else begin
         step_age_reg <= step_age_reg + 1'b1;
      end
   end

   AST_EOB_RAISE: assert property (
      begin_take && cmd_addr == ADDR_EOB |=> end_of_block)
      else $error("end-of-block not raised");
   AST_EOB_HOLD: assert property (
      end_of_block && !eob_ack && !begin_take |=> end_of_block)
      else $error("end-of-block dropped early");
   AST_EOB_END: assert property (
      end_of_block |-> end_out)
      else $error("end line missing in end-of-block");
   AST_EOB_IDLE: assert property (
      end_of_block && eob_ack && !begin_take |=> st_reg == S_IDLE
      && !end_out)
      else $error("no return to idle");
   AST_IN_FS: assert property (
      begin_take && cmd_addr == ADDR_4 && in_now
      |=> function_strobe_line && !end_out)
      else $error("input strobe not raised");
   AST_OUT_FS: assert property (
      begin_take && cmd_addr == ADDR_STEP && !in_now
      |=> function_strobe_line && step_out)
      else $error("output strobe not with step");
   AST_FS_HOLD: assert property (
      function_strobe_line && !step_out && !begin_take
      |=> function_strobe_line)
      else $error("strobe dropped without Begin");
   AST_STEP_W: assert property (
      step_out && !begin_take && step_age_reg == 7'(STEP_CYC - 1)
      |=> !step_out)
      else $error("step not 500 ns");
   AST_STEP_ON: assert property (
      begin_take && cmd_addr == ADDR_STEP
      ##1 (!begin_take) [*8] |-> step_out)
      else $error("step ended early");
   AST_IN_BR: assert property (
      st_reg == S_STEP && step_done && mode_reg[MODE_IN_BIT]
      && !begin_take |=> high_byte_select == $past(two_byte_s))
      else $error("wrong byte branch");
   AST_OUT_BR: assert property (
      st_reg == S_STEP && step_done && !mode_reg[MODE_IN_BIT]
      && !begin_take |=> function_strobe_line && !step_out)
      else $error("no branch to strobe");
   AST_HI_ENTRY: assert property (
      begin_take && cmd_addr == ADDR_3 && in_now
      |=> high_byte_select && !function_strobe_line)
      else $error("high byte not selected");
   AST_HI_DATA: assert property (
      high_byte_select |=> rd_byte == $past(din_hi))
      else $error("high byte not routed");
   AST_END_OUT: assert property (
      begin_take && cmd_addr == ADDR_4 && !in_now
      |=> end_out && !end_of_block)
      else $error("end line wrong");
   AST_TICK: assert property (
      tick |=> !tick [*8])
      else $error("tick too frequent");
   AST_ACK_STAT: assert property (
      ack_s |=> status_word[ST_ACK])
      else $error("acknowledge not in status");
   AST_MODE_DIR: assert property (
      mode_take |=> dir_input == $past(in_now))
      else $error("mode direction not applied");
   AST_AUTO_STEP: assert property (
      begin_take && (cmd_addr == ADDR_AUTO_OUT || cmd_addr == ADDR_AUTO_IN)
      |=> step_out)
      else $error("automatic start gave no step");
   AST_IDLE_LOW: assert property (
      begin_take && cmd_addr == ADDR_IDLE |=> !high_byte_select
      && !function_strobe_line && !step_out && !end_out)
      else $error("idle left lines asserted");
   AST_LOW_DATA: assert property (
      !high_byte_select |=> rd_byte == $past(din_lo))
      else $error("low byte not routed");
   AST_RESET: assert property (disable iff (1'b0)
      sys_rst |=> !step_out && !function_strobe_line && !end_out
      && !end_of_block && !high_byte_select)
      else $error("reset state wrong");
endmodule

// File: tb/periph_model.sv
// Behavioural one- or two-byte peripheral facing the strobe sequencer
`timescale 1ns/10ps

// ----------------------------------------
// Peripheral model
// ----------------------------------------
module periph_model (
   input wire logic mclk, // Clock
   input wire logic sys_rst, // Reset, high
   input wire logic dir_input, // Transfer direction
   input wire logic step_out, // Step from device
   input wire logic function_strobe_line, // Strobe from device
   input wire logic wide, // Act as 16-bit peripheral
   input wire logic stop_req, // Report stop
   input wire logic slow, // Long acknowledge delay
   output logic stop_pin, // Stop status
   output logic busy_pin, // Busy while answer pending
   output logic strobe_ack_pin, // Strobe acknowledge
   output logic two_byte_n_pin, // Low when wide
   output logic [seq_pkg::DIN_W-1:0] data_in_pin // Input lines
);
   import seq_pkg::*;
   localparam logic [DIN_W-1:0] WORD = 16'hC35A;
   logic [4:0] cnt_reg;
   logic pend_reg;
   logic present_reg;
   wire start = dir_input ? step_out : function_strobe_line;
   wire done = dir_input ? function_strobe_line : !function_strobe_line;
   assign stop_pin = stop_req;
   assign busy_pin = pend_reg;
   assign two_byte_n_pin = !wide;
   // Released lines show the inverse so a stale read cannot match
   assign data_in_pin = present_reg ? WORD : ~WORD;
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_reg <= 5'h00;
         pend_reg <= 1'b0;
         present_reg <= 1'b0;
         strobe_ack_pin <= 1'b0;
      end else if (strobe_ack_pin && done) begin
         strobe_ack_pin <= 1'b0;
         present_reg <= 1'b0;
      end else if (pend_reg) begin
         cnt_reg <= cnt_reg - 5'h01;
         if (cnt_reg == 5'h00) begin
            pend_reg <= 1'b0;
            strobe_ack_pin <= 1'b1;
         end
      end else if (start && !strobe_ack_pin) begin
         pend_reg <= 1'b1;
         cnt_reg <= slow ? 5'h14 : 5'h02;
         present_reg <= dir_input;
      end
   end
endmodule

// File: tb/parallel_device_strobe_sequencer_bench.sv
// Directed testbench of the parallel strobe sequencer
`timescale 1ns/10ps

module parallel_device_strobe_sequencer_bench;
   import seq_pkg::*;
   localparam logic [DIN_W-1:0] WORD = 16'hC35A;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic [CMD_W-1:0] cmd_word = '0;
   logic eob_ack = 1'b0, wr_valid = 1'b0, wide = 1'b1;
   logic stop_req = 1'b0, slow = 1'b0;
   logic [DATA_W-1:0] wr_data = '0;
   logic wr_ready, stop_pin, busy_pin, strobe_ack_pin, two_byte_n_pin;
   logic [DIN_W-1:0] data_in_pin;
   logic step_out, function_strobe_line, end_out, end_of_block;
   logic high_byte_select, dir_input, data_mode;
   logic [DATA_W-1:0] data_out, rd_byte;
   logic [STAT_W-1:0] status_word;
   logic [3:0] addr;
   logic [3:0] modes [4] = '{MODE_OUT_DATA, MODE_OUT_CMD, MODE_IN_DATA,
                             MODE_IN_STAT};
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;
   int got;

   strobe_sequencer i_strobe_sequencer (.mclk(mclk), .sys_rst(sys_rst),
      .cmd_valid(cmd_valid), .cmd_word(cmd_word), .eob_ack(eob_ack),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .stop_pin(stop_pin), .busy_pin(busy_pin),
      .strobe_ack_pin(strobe_ack_pin), .two_byte_n_pin(two_byte_n_pin),
      .data_in_pin(data_in_pin), .step_out(step_out),
      .function_strobe_line(function_strobe_line), .end_out(end_out),
      .end_of_block(end_of_block), .high_byte_select(high_byte_select),
      .dir_input(dir_input), .data_mode(data_mode), .data_out(data_out),
      .rd_byte(rd_byte), .status_word(status_word));

   periph_model i_periph_model (.mclk(mclk), .sys_rst(sys_rst),
      .dir_input(dir_input), .step_out(step_out),
      .function_strobe_line(function_strobe_line), .wide(wide),
      .stop_req(stop_req), .slow(slow), .stop_pin(stop_pin),
      .busy_pin(busy_pin), .strobe_ack_pin(strobe_ack_pin),
      .two_byte_n_pin(two_byte_n_pin), .data_in_pin(data_in_pin));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Returns at the falling edge after the taking edge
   task automatic send(input logic b, input logic [3:0] a,
                       input logic [3:0] mode);
      @(negedge mclk);
      cmd_word = '0;
      cmd_word[CMD_MODE_LD] = 1'b1;
      cmd_word[CMD_BEGIN] = b;
      cmd_word[CMD_BR_HI:CMD_BR_LO] = a;
      cmd_word[CMD_MD_HI:CMD_MD_LO] = mode;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
   endtask

   task automatic step_len(input int exp);
      n = 0;
      while (step_out === 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      check(16'(n), 16'(exp));
   endtask

   // Status pins pass synchronisers, so wait under a bound
   task automatic wait_ack(input logic v);
      n = 0;
      while (status_word[ST_ACK] !== v && n < 200) begin
         @(negedge mclk);
         n++;
      end
      check(status_word[ST_ACK], v);
   endtask

   task automatic wrap_up;
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up;
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      check({step_out, function_strobe_line, end_out, end_of_block,
             high_byte_select, dir_input, data_mode, status_word}, '0);
      // Fill until refused, then drain one byte per strobe
      got = 0;
      wr_valid = 1'b1;
      for (int i = 0; i < 20; i++) begin
         wr_data = 8'h10 + 8'(got);
         n = int'(wr_ready === 1'b1);
         @(negedge mclk);
         got += n;
      end
      wr_valid = 1'b0;
      check(16'(got), 16'(FIFO_DEPTH));
      check(wr_ready, 1'b0);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         slow = i[0];
         addr = (i == 1) ? ADDR_3 : (i == 15) ? ADDR_AUTO_OUT : ADDR_STEP;
         send(1'b1, addr, MODE_OUT_DATA);
         check(data_out, 8'h10 + 8'(i));
         check(function_strobe_line, 1'b1);
         if (addr == ADDR_3) begin
            repeat (6) @(negedge mclk);
            check(status_word[ST_BUSY], 1'b1);
         end
         step_len((addr == ADDR_3) ? 0 : STEP_NS / CLK_NS);
         check(function_strobe_line, 1'b1);
         wait_ack(1'b1);
         send(1'b1, ADDR_IDLE, MODE_OUT_DATA);
         check(function_strobe_line, 1'b0);
         wait_ack(1'b0);
      end
      check(wr_ready, 1'b1);
      send(1'b1, ADDR_4, MODE_OUT_DATA);
      check({end_out, end_of_block, function_strobe_line}, 3'b100);
      // Interrupt cleared by acknowledge, by Begin, by reset
      for (int k = 0; k < 3; k++) begin
         send(1'b1, ADDR_EOB, MODE_OUT_DATA);
         repeat (4) @(negedge mclk);
         check({end_out, end_of_block, status_word[ST_IRQ]},
               3'b111);
         if (k == 1) begin
            send(1'b1, ADDR_IDLE, MODE_OUT_DATA);
         end else begin
            @(negedge mclk);
            eob_ack = (k == 0);
            sys_rst = (k == 2);
            @(negedge mclk);
            eob_ack = 1'b0;
            sys_rst = 1'b0;
         end
         check({end_out, end_of_block, high_byte_select},
               '0);
      end
      for (int k = 0; k < 4; k++) begin
         send(1'b0, ADDR_EOB, modes[k]);
         check({dir_input, data_mode, end_of_block},
               {modes[k][MODE_IN_BIT], modes[k][MODE_DATA_BIT], 1'b0});
      end
      // Two-byte peripheral first, then one-byte
      for (int k = 0; k < 2; k++) begin
         wide = (k == 0);
         stop_req = (k == 1);
         slow = (k == 1);
         repeat (4) @(negedge mclk);
         check({status_word[ST_STOP], status_word[ST_TWO_N]},
               {stop_req, !wide});
         stop_req = 1'b0;
         send(1'b1, ADDR_STEP, MODE_IN_DATA);
         step_len(STEP_NS / CLK_NS);
         repeat (2) @(negedge mclk);
         check(high_byte_select, wide);
         check(rd_byte, wide ? WORD[15:8] : WORD[7:0]);
         wait_ack(1'b1);
         send(1'b1, ADDR_3, MODE_IN_DATA);
         check(high_byte_select, 1'b1);
         send(1'b1, ADDR_IDLE, MODE_IN_DATA);
         @(negedge mclk);
         check({high_byte_select, rd_byte},
               {1'b0, WORD[7:0]});
         send(1'b1, ADDR_4, MODE_IN_DATA);
         check({function_strobe_line, end_out}, 2'b10);
         wait_ack(1'b0);
         repeat (3) @(negedge mclk);
         check(function_strobe_line, 1'b1);
         send(1'b1, ADDR_IDLE, MODE_IN_DATA);
         check(function_strobe_line, 1'b0);
      end
      wrap_up;
   end
endmodule
